// [verilog/urt_params.svh]
// Constants of the serial rate, timing and line-coding configuration block
// Assumes: included by the design file and the testbench by its bare name
`ifndef URT_PARAMS_SVH
`define URT_PARAMS_SVH
`define URT_OFF_BAUD 12'h000
`define URT_OFF_IDLE 12'h004
`define URT_OFF_GUARD 12'h008
`define URT_OFF_RATIO 12'h00c
`define URT_OFF_FAULT 12'h010
`define URT_OFF_MANCH 12'h014
`define URT_OFF_IRF 12'h018
`define URT_OFF_MODE 12'h01c
`define URT_OFF_CMD 12'h020
`define URT_OFF_STAT 12'h024
`define URT_OFF_MASK 12'h028
`define URT_RST_RATIO 11'h174
`define URT_OVS_STD 5'h10
`define URT_OVS_EIGHT 5'h08
`define URT_OVS_SYNC 5'h01
`define URT_FRAC_W 3
`define URT_FRAC_STEPS 4'h8
`define URT_MAN_TXPL_LSB 0
`define URT_MAN_TXPP_LSB 8
`define URT_MAN_TXPOL 12
`define URT_MAN_RXPL_LSB 16
`define URT_MAN_RXPP_LSB 24
`define URT_MAN_RXPOL 28
`define URT_MAN_DRIFT 30
`define URT_MODE_SYNC 0
`define URT_MODE_EIGHT 1
`define URT_MODE_CARD 2
`define URT_MODE_OVS16 3
`define URT_CMD_ARM 0
`define URT_CMD_SEND 1
`define URT_ST_TIMEOUT 0
`define URT_ST_GUARD 1
`define URT_ST_FAULT 2
`define URT_NSTAT 3
`endif

// [verilog/urt_pkg.sv]
// Types of the serial rate, timing and line-coding configuration block
// Assumes: urt_params.svh is on the include path
package urt_pkg;
    typedef enum logic [2:0] {
        URT_G_IDLE = 3'b001,
        URT_G_PRE = 3'b010,
        URT_G_GAP = 3'b100
    } urt_gap_t;
    typedef logic [15:0] urt_cnt_t;
endpackage

// [verilog/urt_bit_timer.sv]
// Counts bit periods down from a loaded value and pulses once at zero
// Assumes: bit_tick is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module urt_bit_timer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    input wire logic bit_tick,
    // Result
    output logic running,
    output logic expired
);
    logic [WIDTH-1:0] count_q;
    initial begin
        if (WIDTH < 1 || WIDTH > 16) begin
            $error("urt_bit_timer: WIDTH out of range");
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_q <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                count_q <= value;
                running <= (value != '0);
            end else if (running && bit_tick) begin
                count_q <= count_q - 1'b1;
                if (count_q == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/urt_rate_cfg.sv]
// Baud generator, idle time-out, guard gap, preamble and coding configuration
// Assumes: AHB-Lite single-word master; card clock and line pins are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "urt_params.svh"
module urt_rate_cfg #(
    parameter int RATIO_W = 11
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Line side
    input wire logic card_clk_pin,
    input wire logic rx_pin,
    input wire logic card_error,
    output logic baud_tick,
    output logic bit_tick,
    output logic tx_line,
    output logic preamble_match,
    output logic rx_filtered,
    output logic drift_enable,
    // Interrupt
    output logic irq
);
    import urt_pkg::*;

    initial begin
        if (RATIO_W < 1 || RATIO_W > 11) begin
            $error("urt_rate_cfg: RATIO_W out of range");
        end
    end

    // Registers
    logic [15:0] baud_divisor_q;
    logic [2:0] fraction_field_q;
    logic [15:0] rx_idle_limit_q;
    logic [7:0] guard_gap_q;
    logic [RATIO_W-1:0] smartcard_rate_divisor_q;
    logic [7:0] smartcard_fault_count_q;
    logic [31:0] manchester_config_q;
    logic [7:0] ir_filter_q;
    logic [3:0] mode_q;
    logic [`URT_NSTAT-1:0] stat_q;
    logic [`URT_NSTAT-1:0] mask_q;

    // Bus address phase capture
    logic wr_pend_q;
    logic rd_pend_q;
    logic [11:0] addr_q;
    wire bus_go = hsel && hready && htrans[1];
    wire wr_go = wr_pend_q;
    wire rd_fault = bus_go && !hwrite && (haddr == `URT_OFF_FAULT);
    wire cmd_wr = wr_go && (addr_q == `URT_OFF_CMD);
    wire arm_idle_timer_cmd = cmd_wr && hwdata[`URT_CMD_ARM];
    wire send_cmd = cmd_wr && hwdata[`URT_CMD_SEND];

    // Field views of the coding register
    wire [3:0] send_preamble_len = manchester_config_q[`URT_MAN_TXPL_LSB +: 4];
    wire [1:0] send_preamble_shape = manchester_config_q[`URT_MAN_TXPP_LSB +: 2];
    wire send_manchester_sense = manchester_config_q[`URT_MAN_TXPOL];
    wire [3:0] recv_preamble_len = manchester_config_q[`URT_MAN_RXPL_LSB +: 4];
    wire [1:0] recv_preamble_shape = manchester_config_q[`URT_MAN_RXPP_LSB +: 2];
    wire recv_manchester_sense = manchester_config_q[`URT_MAN_RXPOL];
    wire mode_card = mode_q[`URT_MODE_CARD];

    // Preamble bit at position idx for a shape and sense
    function automatic logic pre_bit(input logic [1:0] shape, input logic sense,
                                     input logic [3:0] idx);
        logic b;
        b = 1'b0;
        case (shape)
            2'b00: b = 1'b1;
            2'b01: b = 1'b0;
            2'b10: b = idx[0];
            2'b11: b = ~idx[0];
            default: b = 1'b1;
        endcase
        pre_bit = b ^ sense;
    endfunction

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            `URT_OFF_BAUD: rd_mux = {13'h0000, fraction_field_q, baud_divisor_q};
            `URT_OFF_IDLE: rd_mux = {16'h0000, rx_idle_limit_q};
            `URT_OFF_GUARD: rd_mux = {24'h00_0000, guard_gap_q};
            `URT_OFF_RATIO: rd_mux = 32'(smartcard_rate_divisor_q);
            `URT_OFF_FAULT: rd_mux = {24'h00_0000, smartcard_fault_count_q};
            `URT_OFF_MANCH: rd_mux = manchester_config_q & 32'h530f_130f;
            `URT_OFF_IRF: rd_mux = {24'h00_0000, ir_filter_q};
            `URT_OFF_MODE: rd_mux = {28'h000_0000, mode_q};
            `URT_OFF_STAT: rd_mux = 32'(stat_q);
            `URT_OFF_MASK: rd_mux = 32'(mask_q);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= bus_go && hwrite;
            rd_pend_q <= bus_go && !hwrite;
            if (bus_go) begin
                addr_q <= haddr;
            end
            if (bus_go && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Register writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            baud_divisor_q <= 16'h0000;
            fraction_field_q <= 3'h0;
            rx_idle_limit_q <= 16'h0000;
            guard_gap_q <= 8'h00;
            smartcard_rate_divisor_q <= RATIO_W'(`URT_RST_RATIO);
            manchester_config_q <= 32'h0000_0000;
            ir_filter_q <= 8'h00;
            mode_q <= 4'h0;
            mask_q <= '0;
        end else if (wr_go) begin
            case (addr_q)
                `URT_OFF_BAUD: begin
                    baud_divisor_q <= hwdata[15:0];
                    fraction_field_q <= hwdata[18:16];
                end
                `URT_OFF_IDLE: rx_idle_limit_q <= hwdata[15:0];
                `URT_OFF_GUARD: guard_gap_q <= hwdata[7:0];
                `URT_OFF_RATIO: smartcard_rate_divisor_q <= hwdata[RATIO_W-1:0];
                `URT_OFF_MANCH: manchester_config_q <= hwdata & 32'h530f_130f;
                `URT_OFF_IRF: ir_filter_q <= hwdata[7:0];
                `URT_OFF_MODE: mode_q <= hwdata[3:0];
                `URT_OFF_MASK: mask_q <= hwdata[`URT_NSTAT-1:0];
                default: mode_q <= mode_q;
            endcase
        end
    end

    // Pin synchronisers
    logic [1:0] card_sync_q;
    logic [1:0] rx_sync_q;
    logic card_prev_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            card_sync_q <= 2'b00;
            rx_sync_q <= 2'b11;
            card_prev_q <= 1'b0;
        end else begin
            card_sync_q <= {card_sync_q[0], card_clk_pin};
            rx_sync_q <= {rx_sync_q[0], rx_pin};
            card_prev_q <= card_sync_q[1];
        end
    end
    wire card_rise = card_sync_q[1] && !card_prev_q;

    // Baud divider with fractional dither
    logic [15:0] div_cnt_q;
    logic [2:0] frac_acc_q;
    logic div_pulse;
    wire div_on = (baud_divisor_q != 16'h0000);
    wire [3:0] frac_sum = {1'b0, frac_acc_q} + {1'b0, fraction_field_q};
    wire frac_extra = frac_sum >= `URT_FRAC_STEPS;
    wire div_src = mode_card ? card_rise : 1'b1;
    always_ff @(posedge ref_clk) begin
        if (reset || !div_on) begin
            div_cnt_q <= 16'h0000;
            frac_acc_q <= 3'h0;
            div_pulse <= 1'b0;
        end else begin
            div_pulse <= 1'b0;
            if (div_src) begin
                if (div_cnt_q == 16'h0000) begin
                    div_pulse <= 1'b1;
                    frac_acc_q <= frac_sum[2:0];
                    div_cnt_q <= (frac_extra && !mode_card) ? baud_divisor_q
                                                            : baud_divisor_q - 16'h0001;
                end else begin
                    div_cnt_q <= div_cnt_q - 16'h0001;
                end
            end
        end
    end

    // Second stage: oversampling or card ratio
    logic [10:0] post_cnt_q;
    wire [4:0] ovs = mode_q[`URT_MODE_SYNC] ? `URT_OVS_SYNC :
                     mode_q[`URT_MODE_EIGHT] ? `URT_OVS_EIGHT :
                     `URT_OVS_STD;
    wire [10:0] post_div = mode_card ? 11'(smartcard_rate_divisor_q) : 11'(ovs);
    wire post_on = div_on && (post_div != 11'h000);
    always_ff @(posedge ref_clk) begin
        if (reset || !post_on) begin
            post_cnt_q <= 11'h000;
            baud_tick <= 1'b0;
        end else begin
            baud_tick <= 1'b0;
            if (div_pulse) begin
                if (post_cnt_q >= post_div - 11'h001) begin
                    post_cnt_q <= 11'h000;
                    baud_tick <= 1'b1;
                end else begin
                    post_cnt_q <= post_cnt_q + 11'h001;
                end
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= baud_tick;
        end
    end

    // Idle time-out
    logic idle_expired;
    urt_bit_timer #(.WIDTH(16)) u_idle (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(arm_idle_timer_cmd),
        .value(rx_idle_limit_q),
        .bit_tick(baud_tick),
        .running(),
        .expired(idle_expired)
    );

    // Send sequencer: preamble then guard gap
    urt_gap_t gap_q;
    logic [3:0] pre_idx_q;
    logic [7:0] gap_cnt_q;
    logic gap_done;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gap_q <= URT_G_IDLE;
            pre_idx_q <= 4'h0;
            gap_cnt_q <= 8'h00;
            gap_done <= 1'b0;
            tx_line <= 1'b1;
        end else begin
            gap_done <= 1'b0;
            case (gap_q)
                URT_G_IDLE: begin
                    tx_line <= 1'b1;
                    if (send_cmd && send_preamble_len != 4'h0) begin
                        gap_q <= URT_G_PRE;
                        pre_idx_q <= 4'h0;
                    end else if (send_cmd && guard_gap_q != 8'h00) begin
                        gap_q <= URT_G_GAP;
                        gap_cnt_q <= guard_gap_q;
                    end
                end
                URT_G_PRE: begin
                    tx_line <= pre_bit(send_preamble_shape, send_manchester_sense, pre_idx_q);
                    if (baud_tick) begin
                        if (pre_idx_q == send_preamble_len - 4'h1) begin
                            gap_q <= (guard_gap_q != 8'h00) ? URT_G_GAP : URT_G_IDLE;
                            gap_cnt_q <= guard_gap_q;
                        end else begin
                            pre_idx_q <= pre_idx_q + 4'h1;
                        end
                    end
                end
                URT_G_GAP: begin
                    tx_line <= 1'b1;
                    if (baud_tick) begin
                        gap_cnt_q <= gap_cnt_q - 8'h01;
                        if (gap_cnt_q == 8'h01) begin
                            gap_q <= URT_G_IDLE;
                            gap_done <= 1'b1;
                        end
                    end
                end
                default: gap_q <= URT_G_IDLE;
            endcase
        end
    end

    // Receive preamble detection and infrared glitch filter
    logic [3:0] rx_pre_cnt_q;
    logic [7:0] flt_cnt_q;
    wire rx_exp = pre_bit(recv_preamble_shape, recv_manchester_sense, rx_pre_cnt_q);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_pre_cnt_q <= 4'h0;
            preamble_match <= 1'b0;
            flt_cnt_q <= 8'h00;
            rx_filtered <= 1'b1;
            drift_enable <= 1'b0;
        end else begin
            drift_enable <= manchester_config_q[`URT_MAN_DRIFT]
                            && mode_q[`URT_MODE_OVS16];
            if (recv_preamble_len == 4'h0) begin
                rx_pre_cnt_q <= 4'h0;
                preamble_match <= 1'b0;
            end else if (baud_tick) begin
                preamble_match <= 1'b0;
                if (rx_filtered != rx_exp) begin
                    rx_pre_cnt_q <= 4'h0;
                end else if (rx_pre_cnt_q == recv_preamble_len - 4'h1) begin
                    rx_pre_cnt_q <= 4'h0;
                    preamble_match <= 1'b1;
                end else begin
                    rx_pre_cnt_q <= rx_pre_cnt_q + 4'h1;
                end
            end
            if (rx_sync_q[1] == rx_filtered) begin
                flt_cnt_q <= 8'h00;
            end else if (flt_cnt_q >= ir_filter_q) begin
                rx_filtered <= rx_sync_q[1];
                flt_cnt_q <= 8'h00;
            end else begin
                flt_cnt_q <= flt_cnt_q + 8'h01;
            end
        end
    end

    // Fault counter, status and interrupt
    wire fault_ev = card_error && mode_card;
    wire idle_on = (rx_idle_limit_q != 16'h0000);
    wire [`URT_NSTAT-1:0] stat_set = {fault_ev, gap_done, idle_expired && idle_on};
    wire stat_wr = wr_go && (addr_q == `URT_OFF_STAT);
    wire [`URT_NSTAT-1:0] stat_clr = stat_wr ? hwdata[`URT_NSTAT-1:0] : '0;
    wire [`URT_NSTAT-1:0] stat_d = ((stat_q & ~stat_clr) | stat_set) & {1'b1, 1'b1, idle_on};
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            smartcard_fault_count_q <= 8'h00;
            stat_q <= '0;
            irq <= 1'b0;
        end else begin
            if (fault_ev) begin
                smartcard_fault_count_q <= (rd_fault ? 8'h00 : smartcard_fault_count_q)
                                           + (smartcard_fault_count_q == 8'hff && !rd_fault
                                              ? 8'h00 : 8'h01);
            end else if (rd_fault) begin
                smartcard_fault_count_q <= 8'h00;
            end
            stat_q <= stat_d;
            irq <= |(stat_d & mask_q);
        end
    end
endmodule
`default_nettype wire

// [tb/urt_line_peer.sv]
// Serial line peer: smart-card clock source and idle receive line
// Assumes: card_run is driven on the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module urt_line_peer (
    // Clock
    input wire logic ref_clk,
    // Control
    input wire logic card_run,
    // Line
    output logic card_clk_pin,
    output logic rx_pin
);
    logic [1:0] div_q;
    initial div_q = 2'h0;
    initial card_clk_pin = 1'b0;
    // Card clock at a quarter of ref_clk, standing low outside transfers
    always @(posedge ref_clk) begin
        div_q <= card_run ? div_q + 2'h1 : 2'h0;
        card_clk_pin <= card_run & div_q[1];
    end
    // Receive line released, pulled up to the idle mark level
    assign rx_pin = 1'b1;
endmodule
`default_nettype wire

// [tb/urt_rate_cfg_sva.sv]
// Checker of bus answers, baud tick timing and drift enable
// Assumes: bound to urt_rate_cfg, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module urt_rate_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Line and interrupt
    input wire logic baud_tick,
    input wire logic bit_tick,
    input wire logic tx_line,
    input wire logic drift_enable,
    input wire logic irq
);
    logic wp_q, known_q, drift_q;
    logic [11:0] wa_q;
    logic [18:0] baud_q;
    logic [3:0] mode_q;
    logic [2:0] quiet_q;
    // Shadow of the written configuration
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wp_q <= 1'b0;
            known_q <= 1'b0;
            drift_q <= 1'b0;
            baud_q <= 19'h0;
            mode_q <= 4'h0;
            quiet_q <= 3'h0;
        end else if (wp_q && hready) begin
            wp_q <= hsel && htrans[1] && hwrite;
            wa_q <= haddr;
            quiet_q <= 3'h0;
            known_q <= known_q | (wa_q == 12'h000);
            if (wa_q == 12'h000) baud_q <= hwdata[18:0];
            if (wa_q == 12'h014) drift_q <= hwdata[30];
            if (wa_q == 12'h01c) mode_q <= hwdata[3:0];
        end else begin
            if (hready) wp_q <= hsel && htrans[1] && hwrite;
            if (hready) wa_q <= haddr;
            if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic settled = known_q && quiet_q >= 3'h3;
    sequence s_rd_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr > 12'h028;
    endsequence
    sequence s_no_tick8;
        !baud_tick [*8];
    endsequence
    property p_ready; hreadyout && !hresp; endproperty
    property p_bit_follow; bit_tick == $past(baud_tick); endproperty
    property p_after_reset; $past(reset) |-> tx_line && !irq && hrdata == 32'h0; endproperty
    property p_unmapped; s_rd_unmapped |=> hrdata == 32'h0; endproperty
    property p_div_zero; settled && baud_q[15:0] == 16'h0 |-> !baud_tick; endproperty
    property p_spacing;
        settled && mode_q == 4'h0 && baud_q[18:16] == 3'h0 && baud_tick |=> s_no_tick8;
    endproperty
    property p_drift; quiet_q >= 3'h3 |-> drift_enable == (drift_q & mode_q[3]); endproperty
    property p_sync_one;
        settled && mode_q == 4'h1 && baud_q == 19'h1 ##1 settled |-> baud_tick;
    endproperty
    a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
    a_bit_follow: assert property (p_bit_follow) else $error("bit tick not one behind");
    a_after_reset: assert property (p_after_reset) else $error("outputs wrong after reset");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_div_zero: assert property (p_div_zero) else $error("tick with divisor zero");
    a_spacing: assert property (p_spacing) else $error("ticks too close");
    a_drift: assert property (p_drift) else $error("drift enable wrong");
    a_sync_one: assert property (p_sync_one) else $error("sync divisor one gap");
endmodule
bind urt_rate_cfg urt_rate_sva u_sva (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .baud_tick(baud_tick),
    .bit_tick(bit_tick), .tx_line(tx_line), .drift_enable(drift_enable), .irq(irq));
`default_nettype wire

// [tb/testbench.sv]
// Register, rate, timer, counter and preamble tests over AHB-Lite
// Assumes: one slave, hready looped from hreadyout, partner on the line
`timescale 1ns/1ps
`default_nettype none
`include "urt_params.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
    import urt_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic card_error = 1'b0, card_run = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd, p, k;
    wire logic [31:0] hrdata;
    wire logic hready, hreadyout, hresp, card_clk_pin, rx_pin, baud_tick, bit_tick;
    wire logic tx_line, preamble_match, rx_filtered, drift_enable, irq;
    int miscompares = 0, checked = 0;
    logic [31:0] mt [3] = '{32'h0, 32'h2, 32'h1};
    logic [31:0] et [3] = '{32'd48, 32'd24, 32'd3};
    assign hready = hreadyout;
    initial forever #12.5 ref_clk = ~ref_clk;
    urt_rate_cfg u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .card_clk_pin(card_clk_pin),
        .rx_pin(rx_pin), .card_error(card_error), .baud_tick(baud_tick), .bit_tick(bit_tick),
        .tx_line(tx_line), .preamble_match(preamble_match), .rx_filtered(rx_filtered),
        .drift_enable(drift_enable), .irq(irq));
    urt_line_peer u_peer (.ref_clk(ref_clk), .card_run(card_run),
        .card_clk_pin(card_clk_pin), .rx_pin(rx_pin));
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask
    // Cycles until the next baud tick
    task automatic period();
        p = 32'h0;
        do begin @(posedge ref_clk); p++; end while (baud_tick !== 1'b1 && p < 5000);
    endtask
    // Counts ticks, or low line cycles, over a span
    task automatic count(input int c, input logic line);
        k = 32'h0;
        repeat (c) begin
            @(posedge ref_clk);
            if (line ? tx_line === 1'b0 : baud_tick === 1'b1) k++;
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rdchk("ratio_rst", `URT_OFF_RATIO, 32'h174);
        rdchk("unmapped", 12'h0fc, 32'h0);
        wr(`URT_OFF_MANCH, 32'hffffffff);
        rdchk("coding", `URT_OFF_MANCH, 32'h530f130f);
        wr(`URT_OFF_IRF, 32'h1a5);
        rdchk("ir_filter", `URT_OFF_IRF, 32'ha5);
        for (int i = 0; i < 3; i++) begin
            wr(`URT_OFF_MODE, mt[i]);
            wr(`URT_OFF_BAUD, 32'h3);
            period();
            period();
            `CHK("period", et[i], p)
        end
        wr(`URT_OFF_BAUD, 32'h0);
        @(posedge ref_clk);
        count(200, 1'b0);
        `CHK("div_zero", 32'h0, k)
        wr(`URT_OFF_MODE, 32'h0);
        wr(`URT_OFF_BAUD, 32'h40002);
        period();
        count(320, 1'b0);
        `CHK("fraction", 32'd8, k)
        wr(`URT_OFF_MODE, 32'h4);
        wr(`URT_OFF_RATIO, 32'h4);
        wr(`URT_OFF_BAUD, 32'h1);
        card_run <= 1'b1;
        period();
        period();
        `CHK("card", 32'd16, p)
        wr(`URT_OFF_RATIO, 32'h0);
        @(posedge ref_clk);
        count(200, 1'b0);
        `CHK("ratio_zero", 32'h0, k)
        card_run <= 1'b0;
        wr(`URT_OFF_MODE, 32'h8);
        wr(`URT_OFF_MANCH, 32'h40000000);
        repeat (3) @(posedge ref_clk);
        `CHK("drift_on", 1'b1, drift_enable)
        wr(`URT_OFF_MODE, 32'h1);
        wr(`URT_OFF_BAUD, 32'h1);
        repeat (3) @(posedge ref_clk);
        `CHK("drift_off", 1'b0, drift_enable)
        wr(`URT_OFF_MASK, 32'h1);
        wr(`URT_OFF_IDLE, 32'ha);
        wr(`URT_OFF_CMD, 32'h1);
        repeat (5) @(posedge ref_clk);
        `CHK("early", 1'b0, irq)
        repeat (30) @(posedge ref_clk);
        `CHK("timeout_irq", 1'b1, irq)
        rdchk("timeout", `URT_OFF_STAT, 32'h1);
        wr(`URT_OFF_STAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHK("irq_clear", 1'b0, irq)
        wr(`URT_OFF_IDLE, 32'h0);
        wr(`URT_OFF_CMD, 32'h1);
        repeat (40) @(posedge ref_clk);
        rdchk("no_timeout", `URT_OFF_STAT, 32'h0);
        wr(`URT_OFF_MODE, 32'h4);
        repeat (3) begin
            @(posedge ref_clk);
            card_error <= 1'b1;
            @(posedge ref_clk);
            card_error <= 1'b0;
        end
        rdchk("faults", `URT_OFF_FAULT, 32'h3);
        rdchk("faults_clr", `URT_OFF_FAULT, 32'h0);
        rdchk("fault_flag", `URT_OFF_STAT, 32'h4);
        wr(`URT_OFF_MODE, 32'h1);
        wr(`URT_OFF_STAT, 32'h7);
        wr(`URT_OFF_GUARD, 32'h3);
        wr(`URT_OFF_MANCH, 32'h104);
        wr(`URT_OFF_CMD, 32'h2);
        count(60, 1'b1);
        `CHK("preamble_zeros", 32'd4, k)
        rdchk("guard_done", `URT_OFF_STAT, 32'h2);
        wr(`URT_OFF_MANCH, 32'h204);
        wr(`URT_OFF_CMD, 32'h2);
        count(60, 1'b1);
        `CHK("preamble_alt", 32'd2, k)
        wr(`URT_OFF_MANCH, 32'h1004);
        wr(`URT_OFF_CMD, 32'h2);
        count(60, 1'b1);
        `CHK("preamble_sense", 32'd4, k)
        wr(`URT_OFF_MANCH, 32'h20004);
        wr(`URT_OFF_CMD, 32'h2);
        count(60, 1'b1);
        `CHK("preamble_ones", 32'd0, k)
        k = 32'h0;
        repeat (20) begin
            @(posedge ref_clk);
            if (preamble_match === 1'b1) k++;
        end
        `CHK("rx_preamble", 32'd10, k)
        `CHK("rx_filtered", 1'b1, rx_filtered)
        end_sim();
    end
endmodule
`default_nettype wire
